// *** lff_regs.vh ***
// Timing constants and thresholds of the LED fault flag logic
`ifndef LFF_REGS_VH
`define LFF_REGS_VH
// Clock rate in kHz
`define LFF_CLK_KHZ 10000
// Times in microseconds
`define LFF_DEGLITCH_US 50
`define LFF_MASK_US 100
`define LFF_HICCUP_US 1000
// Cycle counts of the times above at the 10 MHz clock, sized to their counters
`define LFF_DEGLITCH_CYC 16'h01F4
`define LFF_MASK_CYC 16'h03E8
`define LFF_HICCUP_CYC 16'h2710
// Current to regulation timer in switching cycles
`define LFF_REG_SW_CYC 9'h100
// Counter width
`define LFF_CNT_W 16
`endif

// *** lff_deglitch.v ***
// Deglitch filter: output rises only after input persists, drops at once
`timescale 1ns/10ps
module lff_deglitch #(
  parameter [15:0] COUNT = 16'h0001
) (
  input wire clk_in,
  input wire rst_in,
  input wire enable_in,
  input wire raw_in,
  output reg clean_out
);
  reg [15:0] cnt;
  always @(posedge clk_in) begin
    if (rst_in || !enable_in) begin
      cnt <= 16'h0000;
      clean_out <= 1'b0;
    end else if (!raw_in) begin
      cnt <= 16'h0000;
      clean_out <= 1'b0;
    end else if (cnt < COUNT) begin
      cnt <= cnt + 16'h0001;
    end else begin
      clean_out <= 1'b1;
    end
  end
endmodule

// *** lff_timer.v ***
// One-shot down counter timer, restarted by a pulse
`timescale 1ns/10ps
module lff_timer #(
  parameter [15:0] COUNT = 16'h0001
) (
  input wire clk_in,
  input wire rst_in,
  input wire start_in,
  input wire tick_in,
  output wire busy_out
);
  reg [15:0] cnt;
  always @(posedge clk_in) begin
    if (rst_in) begin
      cnt <= 16'h0000;
    end else if (start_in) begin
      cnt <= COUNT;
    end else if (tick_in && cnt != 16'h0000) begin
      cnt <= cnt - 16'h0001;
    end
  end
  assign busy_out = (cnt != 16'h0000);
endmodule

// *** lff_fault_flag.v ***
// LED open / output short fault supervision with open-drain flag
`timescale 1ns/10ps
`include "lff_regs.vh"

module lff_fault_flag (
  input wire clk_in,
  input wire rst_in,
  input wire enable_in,
  input wire pwm_dim_in,
  input wire sense_low_in,
  input wire vout_low_in,
  input wire analog_dim_above_500mv_in,
  input wire analog_dim_above_400mv_in,
  input wire fault_mask_level_in,
  input wire sw_cycle_tick_in,
  input wire current_limit_in,
  output reg fault_flag_out_n,
  output reg fault_flag_oe_out,
  output reg led_current_on_out,
  output reg hiccup_out,
  output reg hiccup_retry_out
);
  // ==========================================================
  // States of the open-string supervisor
  localparam [2:0] ST_NORMAL = 3'b001;
  localparam [2:0] ST_HICCUP = 3'b010;
  localparam [2:0] ST_RELEASE = 3'b100;

  reg [2:0] state;
  reg [2:0] next_state;
  reg pwm_q;
  reg open_flag;
  reg short_flag;
  reg flag_latched;
  reg [15:0] retry_cnt;
  reg [8:0] reg_cnt;
  wire pwm_rise;
  wire pwm_fall;
  wire mask_busy;
  wire open_raw;
  wire short_raw;
  wire open_ok;
  wire short_ok;
  wire masked;
  wire hiccup_done;
  wire reg_done;
  wire detect_window;
  wire [1:0] fault_raw;
  wire [1:0] fault_ok;
  wire go_hiccup;
  wire go_release;
  wire reopen;
  wire release_ok;
  reg next_open_flag;
  reg next_short_flag;
  reg next_flag_latched;
  genvar ch;

  // ==========================================================
  // Dimming edges and mask timer
  always @(posedge clk_in) begin
    if (rst_in) begin
      pwm_q <= 1'b0;
    end else begin
      pwm_q <= pwm_dim_in;
    end
  end
  assign pwm_rise = pwm_dim_in && !pwm_q;
  assign pwm_fall = !pwm_dim_in && pwm_q;

  // Restarted at every rise, so each dimming cycle opens with a blind spell
  lff_timer #(
    .COUNT(`LFF_MASK_CYC)
  ) u_mask (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .start_in(pwm_rise),
    .tick_in(1'b1),
    .busy_out(mask_busy)
  );

  // ==========================================================
  // Raw detection and deglitch
  // Partial sense short below current limit looks like regulation
  assign open_raw = sense_low_in && !current_limit_in;
  assign short_raw = vout_low_in && analog_dim_above_500mv_in;
  assign masked = !fault_mask_level_in || !analog_dim_above_500mv_in;
  // Faults only count while dimming is high and the mask has run out
  assign detect_window = pwm_dim_in && !mask_busy;
  // Channel 0 watches the string, channel 1 the output
  assign fault_raw = {short_raw, open_raw};
  assign open_ok = fault_ok[0];
  assign short_ok = fault_ok[1];

  generate
    for (ch = 0; ch < 2; ch = ch + 1) begin : g_dg
      lff_deglitch #(
        .COUNT(`LFF_DEGLITCH_CYC)
      ) u_dg (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .enable_in(detect_window),
        .raw_in(fault_raw[ch]),
        .clean_out(fault_ok[ch])
      );
    end
  endgenerate

  // ==========================================================
  // Hiccup retry and regulation timers
  assign hiccup_done = (retry_cnt == 16'h0000);
  assign reg_done = (reg_cnt == 9'h000);

  always @(posedge clk_in) begin
    if (rst_in) begin
      retry_cnt <= 16'h0000;
    end else if (state == ST_HICCUP && hiccup_done) begin
      retry_cnt <= `LFF_HICCUP_CYC;
    end else if (!hiccup_done) begin
      retry_cnt <= retry_cnt - 16'h0001;
    end
  end

  // One pulse per start-up retry while in hiccup
  always @(posedge clk_in) begin
    if (rst_in) begin
      hiccup_retry_out <= 1'b0;
    end else begin
      hiccup_retry_out <= (state == ST_HICCUP) && hiccup_done;
    end
  end

  // Switching cycles since the last rise, reloaded per dimming cycle
  always @(posedge clk_in) begin
    if (rst_in) begin
      reg_cnt <= 9'h000;
    end else if (pwm_rise) begin
      reg_cnt <= `LFF_REG_SW_CYC;
    end else if (sw_cycle_tick_in && !reg_done) begin
      reg_cnt <= reg_cnt - 9'h001;
    end
  end

  // ==========================================================
  // Open-string supervisor
  assign go_hiccup = open_ok && !masked;
  // Hiccup is left only once the string is back, even if masked
  assign go_release = !open_raw && detect_window;
  // An open seen again before release goes straight back to hiccup
  assign reopen = detect_window && open_raw && !masked;
  // Release waits for a rise, a finished timer and dim above 400 mV
  assign release_ok = pwm_rise && (hiccup_done || reg_done)
    && analog_dim_above_400mv_in;

  always @* begin
    next_state = state;
    case (state)
      ST_NORMAL: begin
        if (go_hiccup) begin
          next_state = ST_HICCUP;
        end else begin
          next_state = ST_NORMAL;
        end
      end
      ST_HICCUP: begin
        if (go_release) begin
          next_state = ST_RELEASE;
        end else begin
          next_state = ST_HICCUP;
        end
      end
      ST_RELEASE: begin
        if (reopen) begin
          next_state = ST_HICCUP;
        end else if (release_ok) begin
          next_state = ST_NORMAL;
        end else begin
          next_state = ST_RELEASE;
        end
      end
      default: begin
        next_state = ST_NORMAL;
      end
    endcase
  end

  always @(posedge clk_in) begin
    if (rst_in) begin
      state <= ST_NORMAL;
    end else begin
      state <= next_state;
    end
  end

  // ==========================================================
  // Fault flags
  // Release state keeps the open flag up until the release rise
  always @* begin
    next_open_flag = (next_state != ST_NORMAL);
  end

  always @* begin
    next_short_flag = short_flag;
    if (short_ok) begin
      next_short_flag = 1'b1;
    end else if (pwm_rise && !short_raw) begin
      next_short_flag = 1'b0;
    end
  end

  always @(posedge clk_in) begin
    if (rst_in) begin
      open_flag <= 1'b0;
    end else begin
      open_flag <= next_open_flag;
    end
  end

  always @(posedge clk_in) begin
    if (rst_in) begin
      short_flag <= 1'b0;
    end else begin
      short_flag <= next_short_flag;
    end
  end

  // ==========================================================
  // Flag latch
  // Tracks the fault while dimming is high, frozen from the fall to the next rise
  always @* begin
    next_flag_latched = flag_latched;
    if (pwm_dim_in || pwm_fall) begin
      next_flag_latched = open_flag || short_flag;
    end
  end

  always @(posedge clk_in) begin
    if (rst_in) begin
      flag_latched <= 1'b0;
    end else begin
      flag_latched <= next_flag_latched;
    end
  end

  // ==========================================================
  // Pin drive
  // Data bit is high in reset and low after; only the enable moves, so the pin never drives high
  always @(posedge clk_in) begin
    if (rst_in) begin
      fault_flag_out_n <= 1'b1;
    end else begin
      fault_flag_out_n <= 1'b0;
    end
  end

  // Enable high pulls the pin low
  always @(posedge clk_in) begin
    if (rst_in) begin
      fault_flag_oe_out <= 1'b0;
    end else begin
      fault_flag_oe_out <= flag_latched;
    end
  end

  // ==========================================================
  // Status outputs
  // Short keeps switching; hiccup only from open
  always @(posedge clk_in) begin
    if (rst_in) begin
      led_current_on_out <= 1'b0;
    end else begin
      led_current_on_out <= enable_in && pwm_dim_in && state != ST_HICCUP;
    end
  end

  always @(posedge clk_in) begin
    if (rst_in) begin
      hiccup_out <= 1'b0;
    end else begin
      hiccup_out <= (state == ST_HICCUP);
    end
  end
endmodule

// *** lff_checker.sv ***
// Port checker of the LED fault flag logic
`timescale 1ns/10ps
module lff_checker (
  input wire clk_in,
  input wire rst_in,
  input wire pwm_dim_in,
  input wire sense_low_in,
  input wire vout_low_in,
  input wire fault_mask_level_in,
  input wire fault_flag_out_n,
  input wire fault_flag_oe_out,
  input wire led_current_on_out,
  input wire hiccup_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  reg [15:0] hi = 16'h0000;
  always @(posedge clk_in) begin
    hi <= pwm_dim_in ? hi + 16'h0001 : 16'h0000;
  end
  sequence low_run;
    !pwm_dim_in [*4];
  endsequence
  chk_pin_low: assert property (!$past(rst_in) |-> !fault_flag_out_n)
    else $error("pin data high");
  chk_mask_wait: assert property ($rose(fault_flag_oe_out) |-> hi >= 16'h05DC)
    else $error("flag too early");
  chk_flag_cause: assert property ($rose(fault_flag_oe_out)
    |-> $past(sense_low_in, 3) || $past(vout_low_in, 3))
    else $error("flag without fault");
  chk_frozen_low: assert property (low_run |-> $stable(fault_flag_oe_out))
    else $error("flag moved while low");
  chk_short_nohic: assert property (!sense_low_in [*8] |-> !$rose(hiccup_out))
    else $error("hiccup on short");
  chk_hic_flag: assert property ($rose(hiccup_out) |-> ##[0:3] fault_flag_oe_out)
    else $error("hiccup without flag");
  chk_led_off: assert property (!pwm_dim_in [*2] |-> !led_current_on_out)
    else $error("led on while dim low");
  chk_mask_open: assert property ((!fault_mask_level_in && !vout_low_in) [*8]
    ##0 !fault_flag_oe_out |=> !fault_flag_oe_out)
    else $error("masked flag set");
endmodule
bind lff_fault_flag lff_checker chk (.clk_in, .rst_in, .pwm_dim_in, .sense_low_in,
  .vout_low_in, .fault_mask_level_in, .fault_flag_out_n, .fault_flag_oe_out,
  .led_current_on_out, .hiccup_out);

// *** lff_host.sv ***
// Host model: dimming source and pulled-up flag pin
`timescale 1ns/10ps
module lff_host (
  input wire clk_in,
  input wire [15:0] on_in,
  input wire [15:0] off_in,
  input wire oe_in,
  input wire data_in,
  output reg pwm_out,
  output wire pin_out
);
  reg [15:0] n = 16'h0000;
  initial pwm_out = 1'b0;
  assign pin_out = oe_in ? data_in : 1'b1;
  always @(posedge clk_in) begin
    n <= n + 16'h0001;
    if ((pwm_out && n >= on_in) || (!pwm_out && n >= off_in)) begin
      pwm_out <= !pwm_out && on_in != 16'h0000;
      n <= 16'h0001;
    end
  end
endmodule

// *** tb_top.sv ***
// Testbench of the LED fault flag logic
`timescale 1ns/10ps
module tb_top;
  reg clk_in = 1'b0;
  reg rst_in = 1'b1;
  reg sense = 1'b0, vout = 1'b0, mask = 1'b1, ilim = 1'b0, tick = 1'b0;
  reg [15:0] on = 16'h0384;
  reg en = 1'b1, a5 = 1'b1, a4 = 1'b1;
  wire pwm, pin, oe, led, hic, dat, retry;
  integer fails = 0, compares = 0, retries = 0;
  lff_fault_flag dut (.clk_in, .rst_in, .enable_in(en), .pwm_dim_in(pwm),
    .sense_low_in(sense), .vout_low_in(vout), .analog_dim_above_500mv_in(a5),
    .analog_dim_above_400mv_in(a4), .fault_mask_level_in(mask),
    .sw_cycle_tick_in(tick), .current_limit_in(ilim), .fault_flag_out_n(dat),
    .fault_flag_oe_out(oe), .led_current_on_out(led), .hiccup_out(hic),
    .hiccup_retry_out(retry));
  lff_host host (.clk_in, .on_in(on), .off_in(16'h0190), .oe_in(oe), .data_in(dat),
    .pwm_out(pwm), .pin_out(pin));
  initial forever #50 clk_in = !clk_in;
  always @(posedge clk_in) tick <= !tick;
  always @(posedge clk_in) retries <= retries + (retry ? 1 : 0);
  task check(input logic seen, input logic exp, input string what);
    compares = compares + 1;
    if (seen !== exp) begin
      fails = fails + 1;
      $display("wrong value %s expected %b seen %b", what, exp, seen);
    end
  endtask
  task set_in(input logic s, input logic v, input logic m, input logic l);
    @(posedge clk_in);
    sense <= s;
    vout <= v;
    mask <= m;
    ilim <= l;
    on <= on;
  endtask
  task cyc(input integer k);
    repeat (k) @(posedge clk_in);
    #1;
  endtask
  task rise;
    @(posedge pwm);
    #1;
  endtask
  task t_pulse;
    set_in(1'b1, 1'b1, 1'b1, 1'b0);
    repeat (3) rise;
    check(oe, 1'b0, "pulse flag");
    $display("pulse ok");
  endtask
  task t_short;
    @(posedge clk_in);
    on <= 16'h07D0;
    set_in(1'b0, 1'b1, 1'b1, 1'b0);
    rise;
    cyc(1600);
    check(oe, 1'b1, "short flag");
    check(hic, 1'b0, "short hiccup");
    set_in(1'b0, 1'b0, 1'b1, 1'b0);
    rise;
    cyc(20);
    check(oe, 1'b0, "short gone");
    check(led, 1'b1, "led on");
    @(posedge clk_in);
    en <= 1'b0;
    cyc(2);
    check(led, 1'b0, "led disabled");
    @(posedge clk_in);
    en <= 1'b1;
    $display("short ok");
  endtask
  task t_masked;
    set_in(1'b1, 1'b0, 1'b0, 1'b0);
    rise;
    cyc(1800);
    check(oe, 1'b0, "masked open");
    set_in(1'b1, 1'b0, 1'b1, 1'b0);
    a5 <= 1'b0;
    rise;
    cyc(1800);
    check(oe, 1'b0, "dim low open");
    set_in(1'b1, 1'b0, 1'b1, 1'b1);
    a5 <= 1'b1;
    rise;
    cyc(1800);
    check(oe, 1'b0, "limit open");
    $display("masked ok");
  endtask
  task t_open;
    set_in(1'b1, 1'b0, 1'b1, 1'b0);
    rise;
    cyc(1600);
    check(pin, 1'b0, "open pin");
    check(hic, 1'b1, "hiccup");
    check(retries == 1, 1'b1, "first retry");
    repeat (5) rise;
    cyc(1600);
    check(retries == 2, 1'b1, "second retry");
    check(hic, 1'b1, "hiccup held");
    set_in(1'b0, 1'b0, 1'b1, 1'b0);
    cyc(600);
    check(oe, 1'b1, "held flag");
    @(posedge clk_in);
    a5 <= 1'b0;
    a4 <= 1'b0;
    rise;
    cyc(700);
    check(oe, 1'b1, "dim under 400");
    @(posedge clk_in);
    a4 <= 1'b1;
    rise;
    cyc(700);
    check(oe, 1'b0, "released");
    @(posedge clk_in);
    a5 <= 1'b1;
    $display("open ok");
  endtask
  task give_verdict;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    #8000000;
    fails = fails + 1;
    give_verdict;
  end
  initial begin
    repeat (4) @(posedge clk_in);
    rst_in <= 1'b0;
    t_pulse;
    t_short;
    t_masked;
    t_open;
    give_verdict;
  end
endmodule
